// ### ssf_pkg.sv
package ssf_pkg;

  // Operating modes of the surrounding chip as seen by the serial port.
  typedef enum logic [2:0] {
    SSF_MODE_INIT,
    SSF_MODE_NORMAL,
    SSF_MODE_STOP,
    SSF_MODE_SLEEP,
    SSF_MODE_RESTART,
    SSF_MODE_FAILSAFE
  } ssf_mode_t;

  localparam int unsigned SSF_WORD_W    = 32;
  localparam int unsigned SSF_CNT_W     = 6;
  localparam logic [5:0]  SSF_CNT_NONE  = 6'h00;
  localparam logic [5:0]  SSF_CNT_SHORT = 6'h10;
  localparam logic [5:0]  SSF_CNT_LONG  = 6'h20;
  localparam logic [5:0]  SSF_CNT_SAT   = 6'h21;

  localparam int unsigned SSF_ADDR_LSB  = 0;
  localparam int unsigned SSF_ADDR_W    = 7;
  localparam int unsigned SSF_RW_BIT    = 7;
  localparam int unsigned SSF_DATA_LSB  = 8;
  localparam int unsigned SSF_DATA_W    = 8;
  localparam int unsigned SSF_EXT_LSB   = 16;
  localparam int unsigned SSF_EXT_W     = 16;

  // Positions inside the pin synchroniser vector.
  localparam int unsigned SSF_SYN_SCLK  = 0;
  localparam int unsigned SSF_SYN_SEL   = 1;
  localparam int unsigned SSF_SYN_SDI   = 2;
  localparam int unsigned SSF_SYN_W     = 3;

  typedef struct packed {
    logic                  len32;
    logic [SSF_EXT_W-1:0]  ext;
    logic [SSF_DATA_W-1:0] data;
    logic                  write;
    logic [SSF_ADDR_W-1:0] addr;
  } ssf_frame_t;

endpackage

// ### ssf_spi_slave.sv
`timescale 1ns/10ps
// Functional notes
// - Serve transfers in init, normal, stop modes.
// - Ignore transfers in sleep, restart, fail-safe.
// - Full duplex frames of 16 or 32 bits.
// - Select going low starts a frame.
// - Select rising hands the received word on.
// - Select rising releases the serial output.
// - Sample serial input on falling clock edges.
// - Shift serial output after rising clock edges.
// - Address bits 6..0, bit 7 write, 15..8 data.
// - Discard frames unless 0, 16 or 32 clocks.
// - Writes act after select rises, shown next frame.
module ssf_spi_slave (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire ssf_pkg::ssf_mode_t             mode_i,
  input  wire logic                           sclk_i,
  input  wire logic                           select_low_in_n_i,
  input  wire logic                           serial_in_i,
  input  wire logic [ssf_pkg::SSF_WORD_W-1:0] tx_word_i,
  output logic                                serial_out_o,
  output logic                                serial_out_oe_o,
  output ssf_pkg::ssf_frame_t                 rx_frame_o,
  output logic                                rx_valid_o,
  output logic                                err_flag_o
);
  import ssf_pkg::*;

  // Idle pin levels; select rests high so that reset release opens no frame.
  localparam logic [SSF_SYN_W-1:0] SYN_IDLE = SSF_SYN_W'(1) << SSF_SYN_SEL;
  localparam int unsigned          IDX_W    = $clog2(SSF_WORD_W);

  logic [SSF_SYN_W-1:0]  sync1_reg;
  logic [SSF_SYN_W-1:0]  sync2_reg;
  logic                  sclk_d_reg;
  logic                  sel_d_reg;
  logic                  active_reg;
  logic                  clk_bad_reg;
  logic [SSF_CNT_W-1:0]  cnt_reg;
  logic [SSF_WORD_W-1:0] rx_reg;
  logic [SSF_WORD_W-1:0] tx_sh_reg;
  logic                  sclk_s;
  logic                  sel_s;
  logic                  sdi_s;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  sel_fall;
  logic                  sel_rise;
  logic                  enabled;
  logic                  start;
  logic                  finish;
  logic                  good_len;
  logic                  frame_ok;
  logic                  tx_next_bit;

  // Pins come from the master's domain, so two flops precede any logic.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= SYN_IDLE;
      sync2_reg <= SYN_IDLE;
    end else begin
      sync1_reg <= {serial_in_i, select_low_in_n_i, sclk_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign sclk_s = sync2_reg[SSF_SYN_SCLK];
  assign sel_s  = sync2_reg[SSF_SYN_SEL];
  assign sdi_s  = sync2_reg[SSF_SYN_SDI];

  // Select resets high so that release from reset is not seen as a frame start.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_d_reg <= 1'b0;
      sel_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      sel_d_reg  <= sel_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign sel_fall  = ~sel_s & sel_d_reg;
  assign sel_rise  = sel_s & ~sel_d_reg;

  always_comb begin
    case (mode_i)
      SSF_MODE_INIT, SSF_MODE_NORMAL, SSF_MODE_STOP: enabled = 1'b1;
      SSF_MODE_SLEEP, SSF_MODE_RESTART, SSF_MODE_FAILSAFE: enabled = 1'b0;
      default: enabled = 1'b0;
    endcase
  end

  assign start    = sel_fall & enabled;
  assign finish   = active_reg & sel_rise & enabled;
  assign good_len = (cnt_reg == SSF_CNT_NONE) | (cnt_reg == SSF_CNT_SHORT) |
                    (cnt_reg == SSF_CNT_LONG);
  // A clock that is high at either select edge makes the bit count unreliable.
  assign frame_ok = good_len & ~clk_bad_reg & ~sclk_s;
  assign tx_next_bit = tx_sh_reg[1];

  // Frame tracking; a change to sleep, restart or fail-safe mid-frame drops the frame silently.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_reg  <= 1'b0;
      clk_bad_reg <= 1'b0;
      cnt_reg     <= SSF_CNT_NONE;
    end else if (start) begin
      active_reg  <= 1'b1;
      clk_bad_reg <= sclk_s;
      cnt_reg     <= SSF_CNT_NONE;
    end else if (active_reg && (!enabled || sel_rise)) begin
      active_reg <= 1'b0;
    end else if (active_reg && sclk_fall && cnt_reg != SSF_CNT_SAT) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // Bits land at their own index, first bit received is bit 0.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_reg <= '0;
    end else if (active_reg && sclk_fall && cnt_reg < SSF_CNT_LONG) begin
      rx_reg[cnt_reg[IDX_W-1:0]] <= sdi_s;
    end
  end

  // A frame with no clocks is legal but carries nothing to act on.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_frame_o <= '0;
    end else begin
      rx_valid_o <= 1'b0;
      if (finish && frame_ok && cnt_reg != SSF_CNT_NONE) begin
        rx_valid_o       <= 1'b1;
        rx_frame_o.addr  <= rx_reg[SSF_ADDR_LSB +: SSF_ADDR_W];
        rx_frame_o.write <= rx_reg[SSF_RW_BIT];
        rx_frame_o.data  <= rx_reg[SSF_DATA_LSB +: SSF_DATA_W];
        rx_frame_o.ext   <= (cnt_reg == SSF_CNT_LONG) ? rx_reg[SSF_EXT_LSB +: SSF_EXT_W] : '0;
        rx_frame_o.len32 <= (cnt_reg == SSF_CNT_LONG);
      end
    end
  end

  // The error is shown in the next frame's first bit, then cleared.
  // Set and clear fall on different select edges, and set is written last.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_flag_o <= 1'b0;
    end else begin
      if (start) begin
        err_flag_o <= 1'b0;
      end
      if (finish && !frame_ok) begin
        err_flag_o <= 1'b1;
      end
    end
  end

  // The outgoing word is taken at select fall, so a write carried by a frame
  // can only be reflected by the user logic in the following frame.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_sh_reg       <= '0;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (start) begin
      tx_sh_reg       <= {tx_word_i[SSF_WORD_W-1:1], err_flag_o};
      serial_out_o    <= err_flag_o;
      serial_out_oe_o <= 1'b1;
    end else if (!active_reg || !enabled || sel_rise) begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (sclk_rise) begin
      tx_sh_reg    <= tx_sh_reg >> 1;
      serial_out_o <= tx_next_bit;
    end
  end

  property p_release_on_select_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
    (active_reg && sel_rise) |=> !serial_out_oe_o [*2];
  endproperty
  a_release_on_select_rise: assert property (p_release_on_select_rise)
    else $error("serial output still driven after select rose");

  property p_silent_when_disabled;
    @(posedge clk_i) disable iff (!rst_n_i)
    !enabled |=> (!serial_out_oe_o && !active_reg);
  endproperty
  a_silent_when_disabled: assert property (p_silent_when_disabled)
    else $error("port active in a disabled mode");

  property p_start_when_enabled;
    @(posedge clk_i) disable iff (!rst_n_i)
    start |=> (active_reg && serial_out_oe_o && cnt_reg == SSF_CNT_NONE);
  endproperty
  a_start_when_enabled: assert property (p_start_when_enabled)
    else $error("frame not opened on select fall");

  property p_bad_count_discarded;
    @(posedge clk_i) disable iff (!rst_n_i)
    (finish && !good_len) |=> (!rx_valid_o && err_flag_o);
  endproperty
  a_bad_count_discarded: assert property (p_bad_count_discarded)
    else $error("frame with wrong clock count not discarded");

  property p_short_frame_delivered;
    @(posedge clk_i) disable iff (!rst_n_i)
    (finish && frame_ok && cnt_reg == SSF_CNT_SHORT) |=>
      (rx_valid_o && !rx_frame_o.len32 &&
       rx_frame_o.addr == $past(rx_reg[SSF_ADDR_LSB +: SSF_ADDR_W]));
  endproperty
  a_short_frame_delivered: assert property (p_short_frame_delivered)
    else $error("16 bit frame not handed on");

  property p_sample_on_fall;
    @(posedge clk_i) disable iff (!rst_n_i)
    (active_reg && sclk_fall && cnt_reg < SSF_CNT_LONG) |=>
      (rx_reg[$past(cnt_reg[IDX_W-1:0])] == $past(sdi_s));
  endproperty
  a_sample_on_fall: assert property (p_sample_on_fall)
    else $error("input bit not captured on clock fall");

  property p_shift_on_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
    (active_reg && enabled && sclk_rise && !sel_rise && !start) |=>
      (serial_out_o == $past(tx_next_bit) && serial_out_oe_o);
  endproperty
  a_shift_on_rise: assert property (p_shift_on_rise)
    else $error("output not advanced after clock rise");

  property p_idle_holds_rx;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!active_reg && sel_s) |=> $stable(rx_reg);
  endproperty
  a_idle_holds_rx: assert property (p_idle_holds_rx)
    else $error("receive register changed while deselected");

  property p_valid_one_cycle;
    @(posedge clk_i) disable iff (!rst_n_i)
    rx_valid_o |=> !rx_valid_o;
  endproperty
  a_valid_one_cycle: assert property (p_valid_one_cycle)
    else $error("received word pulse longer than one cycle");

endmodule

// ### ssf_master_model.sv
`timescale 1ns/10ps
module ssf_master_model (
  input  wire logic clk_i,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i,
  output logic      sclk_o,
  output logic      select_low_in_n_o,
  output logic      serial_in_o
);
  logic saw_oe;

  initial begin
    sclk_o = 1'b0;
    select_low_in_n_o = 1'b1;
    serial_in_o = 1'b0;
    saw_oe = 1'b0;
  end

  // Between frames the data line toggles so a stale bit never looks like data.
  always @(negedge clk_i) begin
    if (select_low_in_n_o) begin
      serial_in_o <= ~serial_in_o;
    end
  end

  always @(posedge clk_i) begin
    if (serial_out_oe_i === 1'b1) begin
      saw_oe <= 1'b1;
    end
  end

  // One frame of nclk clocks, LSB first; q[i] is read before rising edge i.
  task automatic frame(input int nclk, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    saw_oe = 1'b0;
    @(negedge clk_i);
    select_low_in_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    q[0] = serial_out_i;
    for (int i = 0; i < nclk; i++) begin
      serial_in_o = d[i];
      q[i] = serial_out_i;
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
    select_low_in_n_o = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask

  // Clock pulses sent while this device is not selected.
  task automatic stray(input int n);
    repeat (n) begin
      @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask

  // Leaves the clock high so that the next frame opens with a bad clock level.
  task automatic raise_clk();
    @(negedge clk_i);
    sclk_o = 1'b1;
  endtask
endmodule

// ### ssf_spi_slave_bench.sv
`timescale 1ns/10ps
`define SSF_CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module ssf_spi_slave_bench;
  import ssf_pkg::*;
  logic        clk_i, rst_n_i, sclk, sel_n, serial_in, serial_out, sdo_oe, rx_valid, err_flag;
  ssf_mode_t   mode;
  logic [31:0] tx_word, q;
  ssf_frame_t  rx_frame, last;
  int          mismatches, n_tests, n_valid, v;

  ssf_spi_slave uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode), .sclk_i(sclk),
    .select_low_in_n_i(sel_n), .serial_in_i(serial_in), .tx_word_i(tx_word),
    .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe), .rx_frame_o(rx_frame),
    .rx_valid_o(rx_valid), .err_flag_o(err_flag));
  ssf_master_model master (.clk_i(clk_i), .serial_out_i(serial_out), .serial_out_oe_i(sdo_oe),
    .sclk_o(sclk), .select_low_in_n_o(sel_n), .serial_in_o(serial_in));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(negedge clk_i) begin
    if (rx_valid === 1'b1) begin
      n_valid++;
      last = rx_frame;
    end
  end

  task automatic run(input int nclk, input logic [31:0] d, input logic [31:0] tw);
    @(negedge clk_i);
    tx_word = tw;
    v = n_valid;
    master.frame(nclk, d, q);
  endtask

  task automatic t_short();
    fork
      run(16, 32'h0000_c3a5, 32'h1234_5679);
      begin
        repeat (20) @(negedge clk_i);
        tx_word = 32'h0;
      end
    join
    `SSF_CHK("valid", 1, n_valid - v)
    `SSF_CHK("addr", 7'h25, last.addr)
    `SSF_CHK("write", 1'b1, last.write)
    `SSF_CHK("data", 8'hc3, last.data)
    `SSF_CHK("short", 17'h0, {last.len32, last.ext})
    `SSF_CHK("tx", 15'h2b3c, q[15:1])
    `SSF_CHK("errbit", 1'b0, q[0])
    `SSF_CHK("oe", 1'b1, master.saw_oe)
    `SSF_CHK("release", 2'b00, {sdo_oe, serial_out})
  endtask

  task automatic t_long();
    mode = SSF_MODE_STOP;
    run(32, 32'hbeef_1234, 32'ha5c3_0ff0);
    `SSF_CHK("valid", 1, n_valid - v)
    `SSF_CHK("frame", {1'b1, 16'hbeef, 8'h12, 1'b0, 7'h34}, last)
    `SSF_CHK("tx", tx_word[31:1], q[31:1])
  endtask

  task automatic t_bad();
    int n [5] = '{1, 15, 17, 31, 33};
    foreach (n[k]) begin
      run(n[k], 32'h0000_5a5a, 32'h0);
      `SSF_CHK("drop", 0, n_valid - v)
      `SSF_CHK("err", 1'b1, err_flag)
    end
    master.raise_clk();
    run(16, 32'h0000_5a5a, 32'h0);
    `SSF_CHK("clk high drop", 0, n_valid - v)
    `SSF_CHK("clk high err", 1'b1, err_flag)
    run(0, 32'h0, 32'h0);
    `SSF_CHK("errbit", 1'b1, q[0])
    `SSF_CHK("zero", 2'b00, {err_flag, 1'(n_valid - v)})
  endtask

  task automatic t_modes();
    for (int m = 0; m < 6; m++) begin
      mode = ssf_mode_t'(m);
      run(16, 32'h0000_0101, 32'h0);
      `SSF_CHK("mode valid", int'(m < 3), n_valid - v)
      `SSF_CHK("mode oe", 1'(m < 3), master.saw_oe)
    end
    mode = SSF_MODE_NORMAL;
    fork
      run(16, 32'h0000_0103, 32'h0);
      begin
        repeat (40) @(negedge clk_i);
        mode = SSF_MODE_SLEEP;
      end
    join
    `SSF_CHK("abort valid", 0, n_valid - v)
    `SSF_CHK("abort quiet", 2'b00, {err_flag, sdo_oe})
  endtask

  task automatic t_stray();
    mode = SSF_MODE_NORMAL;
    v = n_valid;
    master.stray(3);
    `SSF_CHK("stray", 2'b00, {err_flag, sdo_oe})
    run(16, 32'h0000_0102, 32'h0);
    `SSF_CHK("after", {8'h01, 1'b0, 7'h02}, {last.data, last.write, last.addr})
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end

  initial begin
    rst_n_i = 1'b0;
    mode = SSF_MODE_NORMAL;
    tx_word = '0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `SSF_CHK("reset", 3'b000, {sdo_oe, serial_out, err_flag})
    `SSF_CHK("reset oe", 1'b0, master.saw_oe)
    t_short();
    t_long();
    t_bad();
    t_modes();
    t_stray();
    complete_run();
  end
endmodule
